// ==== rtl/dsc_pkg.sv ====
// Shared constants and types of the dish supply control interface
package dsc_pkg;
	localparam logic [5:0] DSC_ADDR_UPPER  = 6'h05;
	localparam logic [7:0] DSC_RESET_VALUE = 8'h00;
	localparam logic [3:0] DSC_BIT_LAST    = 4'h7;
	localparam logic [3:0] DSC_BIT_ACK     = 4'h8;
	// Control byte bit positions
	localparam int DSC_POS_STATIC   = 7;
	localparam int DSC_POS_TONE_EN  = 6;
	localparam int DSC_POS_CONT     = 5;
	localparam int DSC_POS_LDC      = 4;
	localparam int DSC_POS_VHIGH    = 3;
	localparam int DSC_POS_POWER    = 2;
	localparam int DSC_POS_MINCUR   = 1;
	localparam int DSC_POS_BOOST    = 0;

	typedef enum logic [2:0] {
		DSC_LVL_13V4 = 3'h0,
		DSC_LVL_18V5 = 3'h1,
		DSC_LVL_14V4 = 3'h2,
		DSC_LVL_19V5 = 3'h3,
		DSC_LVL_22V  = 3'h4,
		DSC_LVL_OFF  = 3'h7
	} dsc_level_t;

	typedef enum logic [4:0] {
		DSC_ST_IDLE  = 5'h01,
		DSC_ST_ADDR  = 5'h02,
		DSC_ST_WRITE = 5'h04,
		DSC_ST_READ  = 5'h08,
		DSC_ST_HOLD  = 5'h10
	} dsc_state_t;

	typedef struct packed {
		logic low_load;
		logic voltage_fault;
		logic tone_fault;
		logic thermal;
		logic overload;
	} dsc_diag_t;

	typedef struct packed {
		dsc_level_t level;
		logic       power_enable;
		logic       line_output_on;
		logic       tone_output_on;
		logic       tone_active;
		logic       static_limit;
		logic       min_current_high;
	} dsc_ctrl_t;
endpackage : dsc_pkg

// ==== rtl/dsc_bus_edge.sv ====
// Bus line sampler with previous-value edge detection
`timescale 1ns/1ps
module dsc_bus_edge
	import dsc_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic line_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	typedef struct packed {
		logic cur;
		logic prev;
	} dsc_edge_state_t;

	dsc_edge_state_t st_reg;
	dsc_edge_state_t st_next;

	always_comb
	begin
		st_next      = st_reg;
		st_next.prev = st_reg.cur;
		st_next.cur  = line_i;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			st_reg <= 2'h3;
		else if (ce_i)
			st_reg <= st_next;
	end

	assign level_o = st_reg.cur;
	assign rise_o  = st_reg.cur & ~st_reg.prev;
	assign fall_o  = ~st_reg.cur & st_reg.prev;
endmodule : dsc_bus_edge

// ==== rtl/dsc_i2c_control.sv ====
// Two-wire target and control byte of the dish supply controller
//
// Contract
// R1 - Data line changes only while bus clock is low.
// R2 - Start: data falls while bus clock high.
// R3 - Stop: data rises while bus clock high.
// R4 - Master sends stop before each start; no repeated starts.
// R5 - Bytes are eight bits, MSB first, each followed by acknowledge.
// R6 - Device drives data low throughout acknowledge pulse after received byte.
// R7 - Master may stop after missing acknowledge to abort.
// R8 - No acknowledge while supply is under lockout threshold.
// R9 - Master may skip acknowledge check and wait one clock.
// R10 - Transfer: start, address, data bytes with acknowledge, stop.
// R11 - Address LSB one reads, zero writes.
// R12 - Address is 000101 then identity pin level.
// R13 - Write byte layout: static, tone en, continuous, ldc, vhigh, power, mincur, boost.
// R14 - Read byte layout: low load, vfault, tone fault, ldc, vhigh, power, thermal, overload.
// R15 - Register clears to zero at power-on.
// R16 - Written data byte replaces all eight control bits.
// R17 - Power on, no boost: ldc and vhigh pick 13.4/18.5/14.4/19.5 V.
// R18 - Power on with boost gives 22 V.
// R19 - Tone enabled: continuous select low lets gate pin gate tone.
// R20 - Tone enable switches tone stage; line output stays on.
// R21 - Static select: clear pulsed limit, set static limit.
// R22 - Min-current select: 6 mA clear, 12 mA set.
// R23 - Power bit clear disables all power blocks.
// R24 - Read shifts byte MSB first; ack continues, nack ends.
// R25 - Readback ldc, vhigh, power equal last written values.
// R26 - Diagnostic flags read one while fault present.
`timescale 1ns/1ps
module dsc_i2c_control
	import dsc_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	input  wire logic              bus_identity_i,
	input  wire logic              undervoltage_lockout_i,
	input  wire logic              tone_gate_pin_i,
	input  wire dsc_pkg::dsc_diag_t diag_i,
	output dsc_pkg::dsc_ctrl_t     ctrl_o,
	output logic [7:0]             control_byte_o
);
	import dsc_pkg::*;

	typedef struct packed {
		dsc_state_t fsm;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic       is_read;
		logic       acking;
		logic [7:0] control_byte;
		logic       sda_oe;
		dsc_ctrl_t  ctrl;
	} dsc_state_all_t;

	dsc_state_all_t st_reg;
	dsc_state_all_t st_next;

	logic scl_lvl;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic sda_rise;
	logic sda_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] read_byte;
	logic [6:0] own_addr;

	dsc_bus_edge u_scl (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.line_i    (scl_i),
		.level_o   (scl_lvl),
		.rise_o    (scl_rise),
		.fall_o    (scl_fall)
	);

	dsc_bus_edge u_sda (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.line_i    (sda_i),
		.level_o   (sda_lvl),
		.rise_o    (sda_rise),
		.fall_o    (sda_fall)
	);

	// Data edges while clock is high are framing, never data
	assign start_seen = sda_fall & scl_lvl & ~scl_rise; // see R2
	assign stop_seen  = sda_rise & scl_lvl & ~scl_rise; // see R3
	assign own_addr   = {DSC_ADDR_UPPER, bus_identity_i}; // see R12

	// Readback mixes live flags with the stored output settings
	assign read_byte = {diag_i.low_load, diag_i.voltage_fault, diag_i.tone_fault, // see R14 R26
		st_reg.control_byte[DSC_POS_LDC],
		st_reg.control_byte[DSC_POS_VHIGH],
		st_reg.control_byte[DSC_POS_POWER], // see R25
		diag_i.thermal, diag_i.overload};

	function automatic dsc_ctrl_t decode_ctrl(input logic [7:0] cb, input logic gate);
		dsc_ctrl_t c;
		c                  = '0;
		c.power_enable     = cb[DSC_POS_POWER];
		c.level            = DSC_LVL_OFF;
		if (cb[DSC_POS_POWER])
		begin
			if (cb[DSC_POS_BOOST])
				c.level = DSC_LVL_22V; // see R18
			else
				c.level = dsc_level_t'({1'b0, cb[DSC_POS_LDC], cb[DSC_POS_VHIGH]}); // see R17
			c.line_output_on   = 1'b1; // see R20
			c.tone_output_on   = cb[DSC_POS_TONE_EN];
			c.tone_active      = cb[DSC_POS_TONE_EN] & (cb[DSC_POS_CONT] | gate); // see R19
			c.static_limit     = cb[DSC_POS_STATIC]; // see R21
			c.min_current_high = cb[DSC_POS_MINCUR]; // see R22
		end
		// Power bit clear leaves every block off whatever else is set, see R23
		return c;
	endfunction : decode_ctrl

	always_comb
	begin
		st_next      = st_reg;
		st_next.ctrl = decode_ctrl(st_reg.control_byte, tone_gate_pin_i);
		if (stop_seen)
		begin
			st_next.fsm    = DSC_ST_IDLE; // see R10
			st_next.sda_oe = 1'b0;
			// A stop that cuts an acknowledge must not leave it pending
			st_next.acking = 1'b0;
		end
		else if (start_seen)
		begin
			// A start inside a transfer restarts address capture; see R4
			st_next.fsm     = DSC_ST_ADDR;
			st_next.bit_cnt = 4'h0;
			st_next.sda_oe  = 1'b0;
			st_next.acking  = 1'b0;
		end
		else
		begin
			case (st_reg.fsm)
				DSC_ST_IDLE:
				begin
					st_next.sda_oe = 1'b0;
				end
				DSC_ST_ADDR, DSC_ST_WRITE:
				begin
					if (scl_rise && st_reg.bit_cnt <= DSC_BIT_LAST)
					begin
						st_next.shift   = {st_reg.shift[6:0], sda_lvl}; // see R5
						st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
					end
					else if (scl_fall && st_reg.bit_cnt == DSC_BIT_ACK && !st_reg.acking)
					begin
						if (undervoltage_lockout_i) // see R8
							st_next.fsm = DSC_ST_HOLD;
						else if (st_reg.fsm == DSC_ST_ADDR)
						begin
							if (st_reg.shift[7:1] == own_addr)
							begin
								st_next.sda_oe  = 1'b1; // see R6
								st_next.acking  = 1'b1;
								st_next.is_read = st_reg.shift[0]; // see R11
							end
							else
								st_next.fsm = DSC_ST_HOLD;
						end
						else
						begin
							st_next.control_byte = st_reg.shift; // see R16 R13
							st_next.sda_oe       = 1'b1; // see R6
							st_next.acking       = 1'b1;
						end
					end
					else if (scl_fall && st_reg.acking)
					begin
						// Release after the ninth pulse, clock low so data may move; see R1
						st_next.acking  = 1'b0;
						st_next.bit_cnt = 4'h0;
						st_next.sda_oe  = 1'b0;
						if (st_reg.fsm == DSC_ST_ADDR && st_reg.is_read)
						begin
							st_next.fsm    = DSC_ST_READ;
							st_next.shift  = {read_byte[6:0], 1'b0};
							st_next.sda_oe = ~read_byte[7]; // see R24
						end
						else
							st_next.fsm = DSC_ST_WRITE;
					end
				end
				DSC_ST_READ:
				begin
					if (scl_fall)
					begin
						if (st_reg.bit_cnt < DSC_BIT_LAST)
						begin
							st_next.sda_oe  = ~st_reg.shift[7]; // see R24 R1
							st_next.shift   = {st_reg.shift[6:0], 1'b0};
							st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
						end
						else if (st_reg.bit_cnt == DSC_BIT_LAST)
						begin
							st_next.sda_oe  = 1'b0;
							st_next.bit_cnt = DSC_BIT_ACK;
						end
						else
						begin
							st_next.bit_cnt = 4'h0;
							st_next.shift   = {read_byte[6:0], 1'b0};
							st_next.sda_oe  = ~read_byte[7];
						end
					end
					else if (scl_rise && st_reg.bit_cnt == DSC_BIT_ACK && sda_lvl)
						st_next.fsm = DSC_ST_HOLD; // see R24
				end
				DSC_ST_HOLD:
				begin
					// Wait for the master to stop; see R7
					st_next.sda_oe = 1'b0;
				end
				default:
				begin
					st_next.fsm    = DSC_ST_IDLE;
					st_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg              <= '0; // see R15
			st_reg.fsm          <= DSC_ST_IDLE;
			st_reg.control_byte <= DSC_RESET_VALUE;
			st_reg.ctrl.level   <= DSC_LVL_OFF;
		end
		else if (ce_i)
			st_reg <= st_next;
	end

	assign sda_o          = 1'b0;
	assign sda_oe_o       = st_reg.sda_oe;
	assign ctrl_o         = st_reg.ctrl;
	assign control_byte_o = st_reg.control_byte;

	a_power_off_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R23
		!$past(st_reg.control_byte[DSC_POS_POWER]) && $past(ce_i)
		|-> ctrl_o.level == DSC_LVL_OFF && !ctrl_o.tone_output_on)
		else $error("power blocks active with power bit clear");

	a_boost_level: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R18
		$past(ce_i) && $past(st_reg.control_byte[DSC_POS_POWER])
		&& $past(st_reg.control_byte[DSC_POS_BOOST]) |-> ctrl_o.level == DSC_LVL_22V)
		else $error("boost did not select top level");

	a_no_ack_lockout: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R8
		ce_i && undervoltage_lockout_i && !st_reg.sda_oe |=> !(st_reg.acking && !$past(st_reg.acking)))
		else $error("acknowledge given under lockout");

	a_ack_held_low: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R6
		st_reg.acking && !stop_seen && !start_seen && !scl_fall |=> st_reg.sda_oe)
		else $error("acknowledge released early");

	a_oe_changes_low: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R1
		$changed(st_reg.sda_oe) && st_reg.sda_oe |-> $past(scl_fall))
		else $error("data driven low while clock high");

	a_stop_to_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R3
		ce_i && stop_seen |=> st_reg.fsm == DSC_ST_IDLE && !sda_oe_o)
		else $error("stop not honoured");

	a_start_to_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R2
		ce_i && start_seen && !stop_seen |=> st_reg.fsm == DSC_ST_ADDR && st_reg.bit_cnt == 4'h0)
		else $error("start not honoured");

	a_write_whole_byte: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R16
		ce_i && $changed(st_reg.control_byte) |-> $past(st_reg.fsm) == DSC_ST_WRITE
		&& $past(st_reg.bit_cnt) == DSC_BIT_ACK)
		else $error("control byte changed outside write ack");

	// Named steps of the acknowledge and read turnaround
	sequence s_addr_taken;
		ce_i && st_reg.fsm == DSC_ST_ADDR && scl_fall && !start_seen && !stop_seen
		&& st_reg.bit_cnt == DSC_BIT_ACK && !st_reg.acking
		&& !undervoltage_lockout_i && st_reg.shift[7:1] == own_addr;
	endsequence

	sequence s_ack_driven;
		sda_oe_o && st_reg.acking;
	endsequence

	sequence s_read_turn;
		ce_i && st_reg.fsm == DSC_ST_ADDR && st_reg.acking && st_reg.is_read
		&& scl_fall && !start_seen && !stop_seen;
	endsequence

	sequence s_read_ack_end;
		ce_i && st_reg.fsm == DSC_ST_READ && st_reg.bit_cnt == DSC_BIT_ACK
		&& scl_fall && !start_seen && !stop_seen;
	endsequence

	sequence s_read_nack;
		ce_i && st_reg.fsm == DSC_ST_READ && st_reg.bit_cnt == DSC_BIT_ACK
		&& scl_rise && sda_lvl && !start_seen && !stop_seen;
	endsequence

	a_ack_on_match: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R6 R12
		s_addr_taken |=> s_ack_driven)
		else $error("own address not acknowledged");

	a_read_first_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R24
		s_read_turn |=> st_reg.fsm == DSC_ST_READ && sda_oe_o != $past(read_byte[7]))
		else $error("first read bit not presented");

	// The byte is fetched again so a flag raised mid-read shows in the next byte
	a_read_reloads: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R24 R26
		s_read_ack_end |=> st_reg.fsm == DSC_ST_READ && st_reg.bit_cnt == 4'h0
		&& sda_oe_o != $past(read_byte[7]))
		else $error("read did not continue after acknowledge");

	a_nack_ends_read: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R24
		s_read_nack |=> st_reg.fsm == DSC_ST_HOLD && !sda_oe_o)
		else $error("read went on after missing acknowledge");

	a_hold_silent: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R7 R8
		st_reg.fsm == DSC_ST_HOLD |-> !sda_oe_o)
		else $error("data driven while ignoring the bus");

	a_level_map: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R17
		$past(ce_i) && $past(st_reg.control_byte[DSC_POS_POWER])
		&& !$past(st_reg.control_byte[DSC_POS_BOOST])
		|-> ctrl_o.level == dsc_level_t'({1'b0, $past(st_reg.control_byte[DSC_POS_LDC]),
		$past(st_reg.control_byte[DSC_POS_VHIGH])}))
		else $error("output level does not follow selects");

	a_tone_gating: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R19
		$past(ce_i) && $past(st_reg.control_byte[DSC_POS_POWER])
		&& $past(st_reg.control_byte[DSC_POS_TONE_EN])
		&& !$past(st_reg.control_byte[DSC_POS_CONT])
		|-> ctrl_o.tone_active == $past(tone_gate_pin_i))
		else $error("tone not gated by the gate pin");

	a_line_stays_on: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R20
		$past(ce_i) && $past(st_reg.control_byte[DSC_POS_POWER])
		|-> ctrl_o.line_output_on && ctrl_o.power_enable)
		else $error("line output off with power set");
endmodule : dsc_i2c_control

// ==== verification/dsc_host_model.sv ====
// Bus master model driving the two-wire control interface
`timescale 1ns/1ps
module dsc_host_model
(
	input  wire logic clk_sys_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial
	begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick
	// Data moves one cycle into the low phase, so the device never sees it with the clock high
	task automatic bit_io(input logic v, output logic r);
		tick(1);
		sda_low_o = ~v;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		r = sda_i;
		scl_o = 1'b0;
	endtask : bit_io
	task automatic start();
		sda_low_o = 1'b1;
		tick(3);
		scl_o = 1'b0;
	endtask : start
	// Every transfer is closed here, also after a refused byte
	task automatic stop();
		tick(1);
		sda_low_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		sda_low_o = 1'b0;
		tick(4);
	endtask : stop
	// Released line on the ninth pulse unless a read byte is acknowledged
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(~mack, a);
		ack = ~a;
	endtask : xfer
endmodule : dsc_host_model

// ==== verification/tb_dish_supply_i2c_control.sv ====
// Self-checking bench of the dish supply two-wire control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %0t: value mismatch", $time); end end
module tb_dish_supply_i2c_control;
	import dsc_pkg::*;
	logic       clk_sys_i = 1'b0;
	logic       rst_i     = 1'b1;
	logic       bus_id    = 1'b0;
	logic       uvlo      = 1'b0;
	logic       gate      = 1'b0;
	logic       ce        = 1'b1;
	dsc_diag_t  diag      = '0;
	logic       scl;
	logic       sda_low;
	logic       sda_oe;
	logic       sda_drv;
	dsc_ctrl_t  ctrl;
	logic [7:0] cbyte;
	int         miscompares = 0;
	int         checks_done = 0;
	int         cycles      = 0;
	// Pull-up: the line is high unless some party pulls it down
	wire logic  sda = ~(sda_low | (sda_oe & ~sda_drv));

	dsc_i2c_control dsc_i2c_control_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_drv), .sda_oe_o(sda_oe), .bus_identity_i(bus_id),
		.undervoltage_lockout_i(uvlo), .tone_gate_pin_i(gate), .diag_i(diag),
		.ctrl_o(ctrl), .control_byte_o(cbyte));
	dsc_host_model dsc_host_model_i (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
		.sda_low_o(sda_low));

	initial
	begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	function automatic dsc_ctrl_t exp_ctrl(input logic [7:0] b, input logic g);
		dsc_ctrl_t c;
		c = '0;
		c.level = DSC_LVL_OFF;
		if (b[DSC_POS_POWER])
		begin
			c.level = b[DSC_POS_BOOST] ? DSC_LVL_22V : dsc_level_t'({1'b0, b[4:3]});
			c.power_enable     = 1'b1;
			c.line_output_on   = 1'b1;
			c.tone_output_on   = b[DSC_POS_TONE_EN];
			c.tone_active      = b[DSC_POS_TONE_EN] & (b[DSC_POS_CONT] | g);
			c.static_limit     = b[DSC_POS_STATIC];
			c.min_current_high = b[DSC_POS_MINCUR];
		end
		return c;
	endfunction : exp_ctrl
	task automatic wr(input logic lsb, input logic [7:0] d, input logic ok);
		logic [7:0] r;
		logic       a;
		dsc_host_model_i.start();
		dsc_host_model_i.xfer({DSC_ADDR_UPPER, lsb, 1'b0}, 1'b0, r, a);
		`CHK(a, ok)
		dsc_host_model_i.xfer(d, 1'b0, r, a);
		`CHK(a, ok)
		dsc_host_model_i.stop();
	endtask : wr
	task automatic rd(input logic [7:0] e);
		logic [7:0] r;
		logic       a;
		dsc_host_model_i.start();
		dsc_host_model_i.xfer({DSC_ADDR_UPPER, bus_id, 1'b1}, 1'b0, r, a);
		`CHK(a, 1'b1)
		dsc_host_model_i.xfer(8'hff, 1'b1, r, a);
		`CHK(r, e)
		dsc_host_model_i.xfer(8'hff, 1'b0, r, a);
		`CHK(r, e)
		dsc_host_model_i.stop();
	endtask : rd
	// Levels, boost, tone, limits and power-off, both identity pin levels
	task automatic sc_write();
		logic [7:0] tbl [8] = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h1d, 8'hc6, 8'h64, 8'hfb};
		for (int i = 0; i < 8; i++)
		begin
			bus_id = i[0];
			wr(i[0], tbl[i], 1'b1);
			`CHK(cbyte, tbl[i])
			for (int g = 0; g < 2; g++)
			begin
				gate = g[0];
				cyc(4);
				`CHK(ctrl, exp_ctrl(tbl[i], gate))
			end
		end
	endtask : sc_write
	// Other address and supply lockout leave the byte alone
	task automatic sc_refuse();
		bus_id = 1'b0;
		wr(1'b1, 8'h1c, 1'b0);
		`CHK(cbyte, 8'hfb)
		uvlo = 1'b1;
		wr(1'b0, 8'h1c, 1'b0);
		`CHK(cbyte, 8'hfb)
		uvlo = 1'b0;
	endtask : sc_refuse
	task automatic sc_read();
		logic [7:0] w [3] = '{8'h1c, 8'h08, 8'h00};
		dsc_diag_t  d [3] = '{5'h15, 5'h0a, 5'h00};
		for (int i = 0; i < 3; i++)
		begin
			wr(bus_id, w[i], 1'b1);
			diag = d[i];
			rd({d[i][4:2], w[i][4:2], d[i][1:0]});
		end
	endtask : sc_read
	// Master ignores every acknowledge and streams two data bytes; the last one stays
	task automatic sc_blind();
		logic [7:0] r;
		logic       a;
		dsc_host_model_i.start();
		dsc_host_model_i.xfer({DSC_ADDR_UPPER, bus_id, 1'b0}, 1'b0, r, a);
		dsc_host_model_i.xfer(8'h0c, 1'b0, r, a);
		`CHK(cbyte, 8'h0c)
		dsc_host_model_i.xfer(8'h14, 1'b0, r, a);
		dsc_host_model_i.stop();
		`CHK(cbyte, 8'h14)
	endtask : sc_blind
	// Low enable freezes the outputs even though the gate pin moves
	task automatic sc_freeze();
		gate = 1'b0;
		wr(bus_id, 8'h44, 1'b1);
		cyc(2);
		ce   = 1'b0;
		gate = 1'b1;
		cyc(4);
		`CHK(ctrl, exp_ctrl(8'h44, 1'b0))
		ce = 1'b1;
		cyc(2);
		`CHK(ctrl, exp_ctrl(8'h44, 1'b1))
		gate = 1'b0;
	endtask : sc_freeze
	initial
	begin
		cyc(8);
		rst_i = 1'b0;
		cyc(2);
		`CHK(cbyte, DSC_RESET_VALUE)
		`CHK(ctrl, exp_ctrl(8'h00, gate))
		sc_write();
		sc_refuse();
		sc_read();
		sc_blind();
		sc_freeze();
		report_and_stop();
	end
endmodule : tb_dish_supply_i2c_control
